// file: hw/parallel_slave_port.sv
// Parallel slave port top
`timescale 1ns/1ps
`default_nettype none
`include "psp_cfg.svh"
module parallel_slave_port import psp_pkg::*; #(
  parameter int DW = `PSP_DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] control_port_direction_i,
  input wire logic [3:0] port_config_field_i,
  input wire logic [1:0] pwm_mode_i,
  input wire logic [2:0] control_port_i,
  input wire logic [DW-1:0] data_pin_i,
  output logic [DW-1:0] data_pin_o,
  output logic [DW-1:0] data_pin_oe_n_o,
  input wire logic sw_wr_i,
  input wire logic [DW-1:0] sw_wdata_i,
  input wire logic sw_rd_i,
  input wire logic irq_flag_clr_i,
  output logic [DW-1:0] input_latch_o,
  output logic slave_port_select_o,
  output logic slave_port_irq_flag_o,
  output logic input_buffer_full_o,
  output logic output_buffer_full_o
);
  logic [2:0] strb_s;
  logic [DW-1:0] din_s;
  logic en;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic reading;
  logic [DW-1:0] out_q, out_d, in_q, in_d;
  logic ibf_q, ibf_d, obf_q, obf_d, irq_q, irq_d, drv_q, drv_d, en_q, en_d;
  logic [DW-1:0] oe_n_q;

  psp_sync #(.W(3), .RST_VAL(3'h7)) u_sync_strb (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(control_port_i),
    .q_o(strb_s)
  );
  psp_sync #(.W(DW), .RST_VAL('0)) u_sync_data (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(data_pin_i),
    .q_o(din_s)
  );

  // Mode gating
  assign en = control_port_direction_i[`PSP_SEL_BIT]
    && (pwm_mode_i == `PSP_PWM_SINGLE)
    && (&control_port_direction_i[`PSP_CS_PIN:`PSP_RD_PIN])
    && (port_config_field_i >= `PSP_CFG_MIN);

  psp_strobe u_strobe (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en),
    .cs_n_i(strb_s[`PSP_CS_PIN]),
    .rd_n_i(strb_s[`PSP_RD_PIN]),
    .wr_n_i(strb_s[`PSP_WR_PIN]),
    .wr_end_o(wr_end),
    .rd_start_o(rd_start),
    .rd_end_o(rd_end),
    .reading_o(reading)
  );

  always_comb begin
    out_d = out_q;
    in_d = in_q;
    ibf_d = ibf_q;
    obf_d = obf_q;
    irq_d = irq_q;
    drv_d = drv_q;
    en_d = en;
    if (sw_wr_i) begin
      out_d = sw_wdata_i;
      obf_d = !(reading || rd_start);
    end
    if (rd_start) begin
      drv_d = 1'b1;
      obf_d = 1'b0;
    end
    if (rd_end || !en) begin
      drv_d = 1'b0;
    end
    if (sw_rd_i) begin
      ibf_d = 1'b0;
    end
    if (wr_end) begin
      in_d = din_s;
      ibf_d = 1'b1;
    end
    if (irq_flag_clr_i) begin
      irq_d = 1'b0;
    end
    if (wr_end || rd_end) begin
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= '0;
      in_q <= '0;
      ibf_q <= 1'b0;
      obf_q <= 1'b0;
      irq_q <= 1'b0;
      drv_q <= 1'b0;
      oe_n_q <= '1;
      en_q <= 1'b0;
    end else begin
      out_q <= out_d;
      in_q <= in_d;
      ibf_q <= ibf_d;
      obf_q <= obf_d;
      irq_q <= irq_d;
      drv_q <= drv_d;
      oe_n_q <= {DW{!drv_d}};
      en_q <= en_d;
    end
  end

  assign data_pin_o = out_q;
  assign data_pin_oe_n_o = oe_n_q;
  assign input_latch_o = in_q;
  assign slave_port_select_o = en_q;
  assign slave_port_irq_flag_o = irq_q;
  assign input_buffer_full_o = ibf_q;
  assign output_buffer_full_o = obf_q;
endmodule : parallel_slave_port
`default_nettype wire

// file: hw/psp_cfg.svh
// Constants for the parallel slave port
//
// Operation
// - Slave select bit enables port unless dual/quad PWM
// - Master accesses data latch asynchronously, one byte
// - Control pins: read, write, chip select strobes
// - Strobe pin directions must be inputs
// - Analog config field must be 1010..1111
// - Write spans CS and WR low; latch on end
// - Write end sets interrupt and input-full flags
// - Read start drives latch, clears output-full
// - Software write during read drives, no flag
// - Read end releases pins, sets interrupt flag
// - Input-full and output-full flags stay readable
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH
`define PSP_DATA_W 8
`define PSP_SEL_BIT 4
`define PSP_RD_PIN 0
`define PSP_WR_PIN 1
`define PSP_CS_PIN 2
`define PSP_CFG_MIN 4'ha
`define PSP_PWM_SINGLE 2'h0
`endif

// file: hw/psp_pkg.sv
// Types for the parallel slave port
package psp_pkg;
  typedef enum logic [2:0] {
    PSP_IDLE = 3'b001,
    PSP_WRITE = 3'b010,
    PSP_READ = 3'b100
  } psp_state_t;
endpackage : psp_pkg

// file: hw/psp_strobe.sv
// Access detector on synchronized strobes
`timescale 1ns/1ps
`default_nettype none
module psp_strobe import psp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic wr_end_o,
  output logic rd_start_o,
  output logic rd_end_o,
  output logic reading_o
);
  psp_state_t st_q;
  psp_state_t st_d;
  always_comb begin
    st_d = st_q;
    wr_end_o = 1'b0;
    rd_start_o = 1'b0;
    rd_end_o = 1'b0;
    case (st_q)
      PSP_IDLE: begin
        if (en_i && !cs_n_i && !wr_n_i) begin
          st_d = PSP_WRITE;
        end else if (en_i && !cs_n_i && !rd_n_i) begin
          st_d = PSP_READ;
          rd_start_o = 1'b1;
        end
      end
      PSP_WRITE: begin
        if (cs_n_i || wr_n_i || !en_i) begin
          st_d = PSP_IDLE;
          wr_end_o = en_i;
        end
      end
      PSP_READ: begin
        if (cs_n_i || rd_n_i || !en_i) begin
          st_d = PSP_IDLE;
          rd_end_o = 1'b1;
        end
      end
      default: st_d = PSP_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= PSP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end
  assign reading_o = (st_q == PSP_READ);
endmodule : psp_strobe
`default_nettype wire

// file: hw/psp_sync.sv
// Two-flop synchronizer
`timescale 1ns/1ps
`default_nettype none
module psp_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule : psp_sync
`default_nettype wire

// file: verif/parallel_slave_port_tb.sv
// Testbench for the parallel slave port
`timescale 1ns/1ps
`default_nettype none
module parallel_slave_port_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, sw_wr_i = 1'b0, sw_rd_i = 1'b0, irq_flag_clr_i = 1'b0;
  logic [7:0] control_port_direction_i = 8'h17, sw_wdata_i = 8'h00;
  logic [3:0] port_config_field_i = 4'ha;
  logic [1:0] pwm_mode_i = 2'h0;
  logic [2:0] control_port_i;
  logic [7:0] data_pin_i, data_pin_o, data_pin_oe_n_o, input_latch_o, bus, q;
  logic slave_port_select_o, slave_port_irq_flag_o, input_buffer_full_o, output_buffer_full_o;
  logic [7:0] fl;
  int mismatches = 0, compares = 0;
  always #10 clk_i = ~clk_i;
  assign data_pin_i = (data_pin_oe_n_o & bus) | (~data_pin_oe_n_o & data_pin_o);
  assign fl = {5'h0, slave_port_irq_flag_o, input_buffer_full_o, output_buffer_full_o};
  psp_master m_u (.clk_i, .pin_i(data_pin_i), .ctl_o(control_port_i), .bus_o(bus));
  parallel_slave_port dut_u (.*);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(posedge clk_i);
    #1 s = 1'b1;
    @(posedge clk_i);
    #1 s = 1'b0;
  endtask : pulse
  task automatic t_write;
    m_u.xfer(3'h1, 8'ha5, 4, q);
    chk("latch", 8'ha5, input_latch_o);
    chk("flags", 8'h06, fl);
    chk("sel", 8'h01, {7'h0, slave_port_select_o});
    pulse(sw_rd_i);
    pulse(irq_flag_clr_i);
    chk("flags", 8'h00, fl);
    $display("write done");
  endtask : t_write
  task automatic t_read;
    sw_wdata_i = 8'h3c;
    pulse(sw_wr_i);
    chk("flags", 8'h01, fl);
    m_u.xfer(3'h2, 8'h00, 6, q);
    chk("rdata", 8'h3c, q);
    chk("oe_n", 8'hff, data_pin_oe_n_o);
    chk("flags", 8'h04, fl);
    pulse(irq_flag_clr_i);
    $display("read done");
  endtask : t_read
  task automatic t_mid;
    sw_wdata_i = 8'h5a;
    fork
      m_u.xfer(3'h2, 8'h00, 10, q);
      begin
        repeat (5) @(posedge clk_i);
        pulse(sw_wr_i);
      end
    join
    chk("rdata", 8'h5a, q);
    chk("flags", 8'h04, fl);
    pulse(irq_flag_clr_i);
    $display("mid done");
  endtask : t_mid
  task automatic t_off;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      #1 control_port_direction_i = (i == 0) ? 8'h07 : (i == 1) ? 8'h13 : 8'h17;
      port_config_field_i = (i == 2) ? 4'h9 : 4'ha;
      pwm_mode_i = (i == 3) ? 2'h2 : 2'h0;
      m_u.xfer(3'h1, 8'h77, 4, q);
      chk("sel", 8'h00, {7'h0, slave_port_select_o});
      chk("latch", 8'ha5, input_latch_o);
      chk("flags", 8'h00, fl);
    end
    $display("off done");
  endtask : t_off
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_write;
    t_read;
    t_mid;
    t_off;
    stop_test;
  end
  initial begin
    #50us;
    mismatches++;
    stop_test;
  end
endmodule : parallel_slave_port_tb
`default_nettype wire

// file: verif/psp_master.sv
// External bus master model
`timescale 1ns/1ps
`default_nettype none
module psp_master (
  input wire logic clk_i,
  input wire logic [7:0] pin_i,
  output logic [2:0] ctl_o,
  output logic [7:0] bus_o
);
  initial begin
    ctl_o = 3'h7;
    bus_o = 8'h00;
  end
  // One whole byte per access, strobes held n edges
  task automatic xfer(input logic [2:0] c, input logic [7:0] d, input int n, output logic [7:0] q);
    @(posedge clk_i);
    #1 ctl_o = c;
    bus_o = d;
    repeat (n) @(posedge clk_i);
    q = pin_i;
    #1 ctl_o = 3'h7;
    // Data held past the strobe release, so a write end still sees it
    repeat (4) @(posedge clk_i);
    #1 bus_o = ~d;
  endtask : xfer
endmodule : psp_master
`default_nettype wire

// file: verif/psp_sva.sv
// Checker for the parallel slave port
`timescale 1ns/1ps
`default_nettype none
module psp_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] control_port_direction_i,
  input wire logic [2:0] control_port_i,
  input wire logic [7:0] data_pin_o,
  input wire logic [7:0] data_pin_oe_n_o,
  input wire logic sw_wr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_rd_i,
  input wire logic slave_port_select_o,
  input wire logic slave_port_irq_flag_o,
  input wire logic input_buffer_full_o,
  input wire logic output_buffer_full_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_drv; $fell(data_pin_oe_n_o[0]) |-> $past(control_port_i, 2) == 3'h2; endproperty
  a_drv: assert property (p_drv) else $error("drv");
  property p_obf; $fell(data_pin_oe_n_o[0]) |-> ##[0:1] !output_buffer_full_o; endproperty
  a_obf: assert property (p_obf) else $error("obf");
  property p_rel; $rose(data_pin_oe_n_o[0]) |-> ##[0:1] slave_port_irq_flag_o; endproperty
  a_rel: assert property (p_rel) else $error("rel");
  property p_ibf; $rose(input_buffer_full_o) |-> slave_port_irq_flag_o; endproperty
  a_ibf: assert property (p_ibf) else $error("ibf");
  property p_icl; $fell(input_buffer_full_o) |-> $past(sw_rd_i); endproperty
  a_icl: assert property (p_icl) else $error("icl");
  property p_ost; $rose(output_buffer_full_o) |-> $past(sw_wr_i); endproperty
  a_ost: assert property (p_ost) else $error("ost");
  property p_out; sw_wr_i |=> data_pin_o == $past(sw_wdata_i); endproperty
  a_out: assert property (p_out) else $error("out");
  property p_sel; slave_port_select_o |-> $past(control_port_direction_i[4]); endproperty
  a_sel: assert property (p_sel) else $error("sel");
  cover property ($rose(input_buffer_full_o));
  cover property ($fell(data_pin_oe_n_o[0]));
  cover property (sw_wr_i && !data_pin_oe_n_o[0]);
endmodule : psp_sva
bind parallel_slave_port psp_sva chk_u (.*);
`default_nettype wire
